// ==== inc/lio_consts.vh ====
// Constants of the logical input and output signal bank
// What this block does
// - Thirty-two logical input bits, each set by operator or supervisor.
// - Thirty-two logical output bits carry user logic results onward.
// - Output bits feed functions, setting groups, relays, LEDs, readback.
// - Input bits take set and clear from mimic switch and supervisor.
// - Every input bit is forced to zero on device restart.
// - Each input bit selects either latching hold mode or pulse mode.
// - Hold mode: set drives one, stays until clear or restart.
// - Pulse mode: set drives one, bit returns to zero 5 ms later.
// - Every edge of every bit makes an event, in two groups.
// - A setting stores ON events only, OFF events only, or both.
// - Each stored event carries the timestamp of its transition.
`ifndef LIO_CONSTS_VH
`define LIO_CONSTS_VH

// ----------------------------------------------------------------------
// Bank geometry
// ----------------------------------------------------------------------
`define LIO_NUM_BITS        32
`define LIO_IDX_W           5
`define LIO_SLOT_W          6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LIO_CLK_PERIOD_NS   8
`define LIO_PULSE_NS        5000000
// Pulse length in clock cycles: 5 ms at the 8 ns clock
`define LIO_PULSE_CYC       20'h98968
`define LIO_PULSE_CNT_W     20

// ----------------------------------------------------------------------
// Event filter settings
// ----------------------------------------------------------------------
`define LIO_FILT_BOTH       2'h0
`define LIO_FILT_ON_ONLY    2'h1
`define LIO_FILT_OFF_ONLY   2'h2

// ----------------------------------------------------------------------
// Event groups
// ----------------------------------------------------------------------
`define LIO_GRP_OUTPUT      1'h0
`define LIO_GRP_INPUT       1'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LIO_RST_BITS        32'h00000000
`define LIO_RST_PTR         6'h00

`endif

// ==== design/lio_input_cell.v ====
// One logical input bit with hold and pulse modes
`timescale 1ns/10ps
`default_nettype none
`include "lio_consts.vh"
module lio_input_cell
#(
    parameter                 CNT_W        = `LIO_PULSE_CNT_W,
    parameter [CNT_W-1:0]     PULSE_CYCLES = `LIO_PULSE_CYC
)
(
    // Clock and reset
    input  wire               clk_sys_in,
    input  wire               rst_n_in,
    // Commands
    input  wire               set_in,
    input  wire               clr_in,
    input  wire               pulse_mode_in,
    // State
    output reg                state_out
);

localparam [CNT_W-1:0] LOAD_VAL = PULSE_CYCLES - 1'b1;
localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

reg  [CNT_W-1:0]          cnt;

// ----------------------------------------------------------------------
// Bit state and pulse timer
// ----------------------------------------------------------------------
always @(posedge clk_sys_in)
begin
    if (!rst_n_in)
    begin
        state_out <= 1'b0;
        cnt       <= CNT_ZERO;
    end
    else if (set_in)
    begin
        state_out <= 1'b1;
        cnt       <= LOAD_VAL;
    end
    else if (clr_in)
    begin
        state_out <= 1'b0;
        cnt       <= CNT_ZERO;
    end
    else if (pulse_mode_in && state_out)
    begin
        if (cnt == CNT_ZERO)
            state_out <= 1'b0;
        else
            cnt <= cnt - 1'b1;
    end
end

endmodule
`default_nettype wire

// ==== design/lio_evt_slot.v ====
// Edge detector and one-deep event holder for one bank bit
`timescale 1ns/10ps
`default_nettype none
module lio_evt_slot
#(
    parameter                 TS_W = 32
)
(
    // Clock and reset
    input  wire               clk_sys_in,
    input  wire               rst_n_in,
    // Watched bit and time
    input  wire               bit_in,
    input  wire [TS_W-1:0]    ts_in,
    // Filter
    input  wire               allow_on_in,
    input  wire               allow_off_in,
    // Drain side
    input  wire               grant_in,
    output reg                pend_out,
    output reg                on_out,
    output reg  [TS_W-1:0]    ts_out,
    output reg                overrun_out
);

reg                       prev;
wire                      rise;
wire                      fall;
wire                      hit;

assign rise = bit_in & ~prev;
assign fall = ~bit_in & prev;
assign hit  = (rise & allow_on_in) | (fall & allow_off_in);

// ----------------------------------------------------------------------
// Capture; a new edge wins over the grant in the same cycle
// ----------------------------------------------------------------------
always @(posedge clk_sys_in)
begin
    if (!rst_n_in)
    begin
        prev        <= 1'b0;
        pend_out    <= 1'b0;
        on_out      <= 1'b0;
        ts_out      <= {TS_W{1'b0}};
        overrun_out <= 1'b0;
    end
    else
    begin
        prev <= bit_in;
        if (hit)
        begin
            pend_out <= 1'b1;
            on_out   <= rise;
            ts_out   <= ts_in;
            if (pend_out && !grant_in)
                overrun_out <= 1'b1;
        end
        else if (grant_in)
            pend_out <= 1'b0;
    end
end

endmodule
`default_nettype wire

// ==== design/lio_bank.v ====
// Logical input and output signal bank with event generation
`timescale 1ns/10ps
`default_nettype none
`include "lio_consts.vh"
module lio_bank
#(
    parameter                 TS_W         = 32,
    parameter                 CNT_W        = `LIO_PULSE_CNT_W,
    parameter [CNT_W-1:0]     PULSE_CYCLES = `LIO_PULSE_CYC
)
(
    // Clock and reset
    input  wire                      clk_sys_in,
    input  wire                      rst_n_in,
    // Mimic switch commands, one-cycle pulses
    input  wire [`LIO_NUM_BITS-1:0]  mimic_set_in,
    input  wire [`LIO_NUM_BITS-1:0]  mimic_clr_in,
    // Supervisory commands, one-cycle pulses
    input  wire [`LIO_NUM_BITS-1:0]  scada_set_in,
    input  wire [`LIO_NUM_BITS-1:0]  scada_clr_in,
    // Configuration
    input  wire [`LIO_NUM_BITS-1:0]  pulse_mode_in,
    input  wire [1:0]                event_filter_in,
    // User logic results and time base
    input  wire [`LIO_NUM_BITS-1:0]  logic_result_in,
    input  wire [TS_W-1:0]           timestamp_in,
    // Bank states
    output wire [`LIO_NUM_BITS-1:0]  logical_in_out,
    output reg  [`LIO_NUM_BITS-1:0]  logical_out_out,
    // Event stream
    output reg                       evt_valid_out,
    input  wire                      evt_ready_in,
    output reg                       evt_group_out,
    output reg  [`LIO_IDX_W-1:0]     evt_index_out,
    output reg                       evt_on_out,
    output reg  [TS_W-1:0]           evt_time_out,
    // Lost event flags per group
    output reg                       evt_overrun_out_grp_out,
    output reg                       evt_overrun_in_grp_out
);

localparam NSLOT = 2 * `LIO_NUM_BITS;

// ----------------------------------------------------------------------
// Logical inputs
// ----------------------------------------------------------------------
wire [`LIO_NUM_BITS-1:0] any_set;
wire [`LIO_NUM_BITS-1:0] any_clr;

assign any_set = mimic_set_in | scada_set_in;
assign any_clr = mimic_clr_in | scada_clr_in;

genvar gi;
generate
    for (gi = 0; gi < `LIO_NUM_BITS; gi = gi + 1)
    begin : g_in
        lio_input_cell
        #(
            .CNT_W        (CNT_W),
            .PULSE_CYCLES (PULSE_CYCLES)
        )
        u_cell
        (
            .clk_sys_in    (clk_sys_in),
            .rst_n_in      (rst_n_in),
            .set_in        (any_set[gi]),
            .clr_in        (any_clr[gi]),
            .pulse_mode_in (pulse_mode_in[gi]),
            .state_out     (logical_in_out[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------------
// Logical outputs
// ----------------------------------------------------------------------
// Registered copy feeds the matrix, setting groups and readback alike
always @(posedge clk_sys_in)
begin
    if (!rst_n_in)
        logical_out_out <= `LIO_RST_BITS;
    else
        logical_out_out <= logic_result_in;
end

// ----------------------------------------------------------------------
// Event filter
// ----------------------------------------------------------------------
wire allow_on;
wire allow_off;

assign allow_on  = (event_filter_in != `LIO_FILT_OFF_ONLY);
assign allow_off = (event_filter_in != `LIO_FILT_ON_ONLY);

// ----------------------------------------------------------------------
// Event slots: low half output group, high half input group
// ----------------------------------------------------------------------
wire [NSLOT-1:0]      watch_bits;
wire [NSLOT-1:0]      slot_pend;
wire [NSLOT-1:0]      slot_on;
wire [NSLOT-1:0]      slot_over;
wire [NSLOT*TS_W-1:0] slot_ts;
wire [NSLOT-1:0]      slot_grant;

assign watch_bits = {logical_in_out, logical_out_out};

generate
    for (gi = 0; gi < NSLOT; gi = gi + 1)
    begin : g_slot
        lio_evt_slot
        #(
            .TS_W (TS_W)
        )
        u_slot
        (
            .clk_sys_in   (clk_sys_in),
            .rst_n_in     (rst_n_in),
            .bit_in       (watch_bits[gi]),
            .ts_in        (timestamp_in),
            .allow_on_in  (allow_on),
            .allow_off_in (allow_off),
            .grant_in     (slot_grant[gi]),
            .pend_out     (slot_pend[gi]),
            .on_out       (slot_on[gi]),
            .ts_out       (slot_ts[gi*TS_W +: TS_W]),
            .overrun_out  (slot_over[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------------
// Round-robin drain of pending slots into the event stream
// ----------------------------------------------------------------------
reg  [`LIO_SLOT_W-1:0] ptr;
wire                   out_free;
wire                   take;

assign out_free   = ~evt_valid_out | evt_ready_in;
assign take       = out_free & slot_pend[ptr];
assign slot_grant = take ? ({{(NSLOT-1){1'b0}}, 1'b1} << ptr)
                         : {NSLOT{1'b0}};

always @(posedge clk_sys_in)
begin
    if (!rst_n_in)
    begin
        ptr           <= `LIO_RST_PTR;
        evt_valid_out <= 1'b0;
        evt_group_out <= `LIO_GRP_OUTPUT;
        evt_index_out <= {`LIO_IDX_W{1'b0}};
        evt_on_out    <= 1'b0;
        evt_time_out  <= {TS_W{1'b0}};
    end
    else
    begin
        // Hold the pointer only while a pending slot waits for room
        if (!(slot_pend[ptr] && !out_free))
            ptr <= ptr + 1'b1;
        if (take)
        begin
            evt_valid_out <= 1'b1;
            evt_group_out <= ptr[`LIO_SLOT_W-1];
            evt_index_out <= ptr[`LIO_IDX_W-1:0];
            evt_on_out    <= slot_on[ptr];
            evt_time_out  <= slot_ts[ptr*TS_W +: TS_W];
        end
        else if (evt_ready_in)
            evt_valid_out <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Lost event flags, sticky until restart
// ----------------------------------------------------------------------
always @(posedge clk_sys_in)
begin
    if (!rst_n_in)
    begin
        evt_overrun_out_grp_out <= 1'b0;
        evt_overrun_in_grp_out  <= 1'b0;
    end
    else
    begin
        evt_overrun_out_grp_out <= |slot_over[`LIO_NUM_BITS-1:0];
        evt_overrun_in_grp_out  <= |slot_over[NSLOT-1:`LIO_NUM_BITS];
    end
end

endmodule
`default_nettype wire

// ==== test/lio_bank_properties.sv ====
// Port assertions of the logical signal bank
`timescale 1ns/10ps
`default_nettype none
module lio_bank_chk
#(
    parameter             CNT_W        = 20,
    parameter [CNT_W-1:0] PULSE_CYCLES = 20'h98968
)
(
    // Clock, reset and inputs
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic [31:0] mimic_set_in,
    input wire logic [31:0] mimic_clr_in,
    input wire logic [31:0] scada_set_in,
    input wire logic [31:0] scada_clr_in,
    input wire logic [31:0] pulse_mode_in,
    input wire logic [31:0] logic_result_in,
    input wire logic        evt_ready_in,
    // Outputs
    input wire logic [31:0] logical_in_out,
    input wire logic [31:0] logical_out_out,
    input wire logic        evt_valid_out,
    input wire logic        evt_on_out,
    input wire logic [31:0] evt_time_out
);
    wire [31:0] set_w  = mimic_set_in | scada_set_in;
    wire [31:0] clr_w  = (mimic_clr_in | scada_clr_in) & ~set_w;
    wire [31:0] keep_w = logical_in_out & ~pulse_mode_in & ~clr_w;
    integer     hi_cnt;
    // Cycles that input bit 0 has been high since its last set
    always @(posedge clk_sys_in)
        if (!rst_n_in || !(set_w[0] || logical_in_out[0]))
            hi_cnt <= 0;
        else if (set_w[0])
            hi_cnt <= 1;
        else
            hi_cnt <= hi_cnt + 1;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_rst;
        !$past(rst_n_in) |-> (logical_in_out | logical_out_out) == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("bank not cleared");
    property p_out;
        $past(rst_n_in) |-> logical_out_out == $past(logic_result_in);
    endproperty
    a_out: assert property (p_out) else $error("output bit lag");
    property p_set;
        $past(rst_n_in) |-> (logical_in_out & $past(set_w)) == $past(set_w);
    endproperty
    a_set: assert property (p_set) else $error("set not taken");
    property p_hold;
        keep_w != 32'h0 |=> (logical_in_out & $past(keep_w)) == $past(keep_w);
    endproperty
    a_hold: assert property (p_hold) else $error("hold bit lost");
    property p_clr;
        clr_w != 32'h0 |=> (logical_in_out & $past(clr_w)) == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear not taken");
    property p_pend;
        pulse_mode_in[0] && logical_in_out[0] && !set_w[0]
            && hi_cnt == PULSE_CYCLES |=> !logical_in_out[0];
    endproperty
    a_pend: assert property (p_pend) else $error("pulse too long");
    property p_plong;
        pulse_mode_in[0] && logical_in_out[0] && !clr_w[0]
            && hi_cnt < PULSE_CYCLES |=> logical_in_out[0];
    endproperty
    a_plong: assert property (p_plong) else $error("pulse short");
    property p_evt;
        evt_valid_out && !evt_ready_in |=> evt_valid_out
            && $stable(evt_time_out) && $stable(evt_on_out);
    endproperty
    a_evt: assert property (p_evt) else $error("event not held");
endmodule
bind lio_bank lio_bank_chk #(.CNT_W(CNT_W), .PULSE_CYCLES(PULSE_CYCLES))
    i_lio_bank_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .mimic_set_in(mimic_set_in), .mimic_clr_in(mimic_clr_in),
    .scada_set_in(scada_set_in), .scada_clr_in(scada_clr_in),
    .pulse_mode_in(pulse_mode_in), .logic_result_in(logic_result_in),
    .evt_ready_in(evt_ready_in), .logical_in_out(logical_in_out),
    .logical_out_out(logical_out_out), .evt_valid_out(evt_valid_out),
    .evt_on_out(evt_on_out), .evt_time_out(evt_time_out));
`default_nettype wire

// ==== test/lio_evt_sink.sv ====
// Event consumer model with selectable stalling
`timescale 1ns/10ps
`default_nettype none
module lio_evt_sink
(
    // Clock and stall mode: 0 ready, 1 random, 2 never
    input  wire logic       clk_sys_in,
    input  wire logic [1:0] mode_in,
    output var  logic       ready_out
);
    integer seed = 6;
    initial ready_out = 1'b0;
    always @(negedge clk_sys_in)
        ready_out <= mode_in == 2'h0 || mode_in == 2'h1 && $random(seed) % 2;
endmodule
`default_nettype wire

// ==== test/test_lio_bank.sv ====
// Self-checking bench of the logical signal bank
`timescale 1ns/10ps
`default_nettype none
module test_lio_bank;
    localparam P = 16;
    reg         clk_sys_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg  [31:0] ms = 32'h0, mc = 32'h0, ss = 32'h0, sc = 32'h0;
    reg  [31:0] pm = 32'h0, lr = 32'h0, ts = 32'h0;
    reg  [1:0]  flt = 2'h0, mode = 2'h1;
    wire [31:0] lin, lout, etime;
    wire [4:0]  eidx;
    wire        evalid, eready, egrp, eon, ovo, ovi;
    reg  [31:0] m_in, m_out;
    reg  [63:0] chg, pol, ev_v, ev_on;
    reg  [31:0] ev_ts [0:63];
    reg  [1:0]  m_ovr;
    integer     c [0:31];
    integer     i, j, k, n, t, tn = 0, seed = 6, n_errors = 0, comparisons = 0;
    lio_bank #(.PULSE_CYCLES(20'h10)) i_lio_bank (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .mimic_set_in(ms), .mimic_clr_in(mc),
        .scada_set_in(ss), .scada_clr_in(sc), .pulse_mode_in(pm),
        .event_filter_in(flt), .logic_result_in(lr), .timestamp_in(ts),
        .logical_in_out(lin), .logical_out_out(lout), .evt_valid_out(evalid),
        .evt_ready_in(eready), .evt_group_out(egrp), .evt_index_out(eidx),
        .evt_on_out(eon), .evt_time_out(etime),
        .evt_overrun_out_grp_out(ovo), .evt_overrun_in_grp_out(ovi));
    lio_evt_sink i_lio_evt_sink (.clk_sys_in(clk_sys_in), .mode_in(mode),
        .ready_out(eready));
    task check(input [63:0] seen, input [63:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task cmd(input [31:0] a, input [31:0] b, input [31:0] d, input [31:0] e);
    begin
        @(negedge clk_sys_in);
        {ms, mc, ss, sc} <= {a, b, d, e};
        @(negedge clk_sys_in);
        {ms, mc, ss, sc} <= 128'h0;
    end
    endtask
    task drain;
    begin
        n = 0;
        repeat (2) @(negedge clk_sys_in);
        while ((ev_v != 64'h0 || evalid !== 1'b0) && n < 3000)
        begin
            @(negedge clk_sys_in);
            n = n + 1;
        end
        check({n >= 3000, ovi, ovo}, {1'b0, m_ovr});
        tn = tn + 1;
        $display("test %0d done", tn);
    end
    endtask
    // ------------------------------------------------------------------
    // Reference model, updated on the design's own clock edge
    // ------------------------------------------------------------------
    always @(posedge clk_sys_in)
    begin
        chg = {m_in, m_out};
        if (evalid && eready && rst_n_in)
        begin
            k = {egrp, eidx};
            check({1'b1, eon, etime}, {ev_v[k], ev_on[k], ev_ts[k]});
            ev_v[k] = 1'b0;
        end
        if (!rst_n_in)
            {m_in, m_out, ev_v, m_ovr} = 130'h0;
        else
        begin
            m_out = lr;
            for (i = 0; i < 32; i = i + 1)
                if (ms[i] | ss[i])
                begin
                    m_in[i] = 1'b1;
                    c[i] = 1;
                end
                else if (mc[i] | sc[i])
                    m_in[i] = 1'b0;
                else if (pm[i] && m_in[i] && c[i] >= P)
                    m_in[i] = 1'b0;
                else
                    c[i] = c[i] + 1;
        end
        pol = {m_in, m_out};
        chg = rst_n_in ? chg ^ pol : 64'h0;
    end
    always @(negedge clk_sys_in)
    begin
        ts = ts + 32'h1;
        check({lin, lout}, {m_in, m_out});
        for (j = 0; j < 64; j = j + 1)
            if (chg[j] && (flt == 2'h1 ? pol[j] : flt != 2'h2 || !pol[j]))
            begin
                m_ovr[j / 32] = m_ovr[j / 32] | ev_v[j];
                ev_v[j] = 1'b1;
                ev_on[j] = pol[j];
                ev_ts[j] = ts;
            end
    end
    always #4 clk_sys_in = ~clk_sys_in;
    initial
    begin
        #(8 * 60000);
        n_errors = n_errors + 1;
        print_verdict;
    end
    initial
    begin
        repeat (6) @(negedge clk_sys_in);
        rst_n_in <= 1'b1;
        drain;
        cmd(32'h0000FFFF, 32'h0, $random(seed), 32'h0);
        drain;
        cmd(32'h0, $random(seed), 32'h0, 32'h00FF0000);
        drain;
        // Set and clear together: set wins
        cmd(32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 32'h0);
        drain;
        cmd(32'h0, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF);
        drain;
        flt <= 2'h1;
        pm <= $random(seed) | 32'h1;
        cmd(32'hFFFFFFFF, 32'h0, 32'h0, 32'h0);
        repeat (7) @(negedge clk_sys_in);
        cmd(32'h0, 32'h0, 32'h0000000F, 32'h0);
        cmd(32'h0, 32'h00000F00, 32'h0, 32'h0);
        repeat (40) @(negedge clk_sys_in);
        cmd(32'h0, 32'hFFFFFFFF, 32'h0, 32'h0);
        drain;
        pm <= 32'h0;
        for (t = 0; t < 4; t = t + 1)
        begin
            flt <= t[1:0];
            repeat (6)
            begin
                @(negedge clk_sys_in);
                lr <= $random(seed);
                drain;
            end
        end
        // Stream blocked by one event while another bit toggles twice
        mode <= 2'h2;
        @(negedge clk_sys_in);
        lr <= lr ^ 32'h1;
        repeat (80) @(negedge clk_sys_in);
        lr <= lr ^ 32'h20;
        @(negedge clk_sys_in);
        lr <= lr ^ 32'h20;
        // Input bit 7 set and cleared while blocked: input group overrun
        cmd(32'h00000080, 32'h0, 32'h0, 32'h0);
        cmd(32'h0, 32'h00000080, 32'h0, 32'h0);
        repeat (4) @(negedge clk_sys_in);
        mode <= 2'h0;
        drain;
        mode <= 2'h1;
        cmd(32'hFFFFFFFF, 32'h0, 32'h0, 32'h0);
        rst_n_in <= 1'b0;
        repeat (6) @(negedge clk_sys_in);
        rst_n_in <= 1'b1;
        drain;
        print_verdict;
    end
endmodule
`default_nettype wire
